// File: hw/fvq_framer.sv
// Split VQ of feature frames and bit-serial multiframe transmitter
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// How it works
// - Vector: c1..c12, then c0, then log energy
// - Seven element pairs, each own codebook
// - Cepstral books 64 entries, energy book 256
// - Full search, minimum weighted distance wins
// - Cepstral pairs use plain squared distance
// - Energy pair weight diagonal, rate dependent
// - Two codebook sets: 8/11 kHz and 16 kHz
// - Quantize on arrival, keep seven indices
// - Sync, then header, then frame packets
// - Every multiframe exactly 144 octets long
// - Octets ascending, bit 1 sent first
// - Multi-bit fields sent LSB first
// - CRC sent highest-order term first
// - Side-by-side fields sent left to right
// - Multiframe opens with sync word, LSB first
// - Inverse sync words may pad idle time
// - No inverse sync needed between multiframes
// - Frame pairs get 4-bit CRC, twelve pairs
// - Multiframe counter starts 0001, wraps mod 16
// - Header (31,16) code plus even parity
// - Unused trailing slots of last multiframe zero
////////////////////////////////////////////////////////////////////////////
module fvq_framer (
   input wire logic clk, // 25 MHz clock
   input wire logic rst_n, // Async reset, active low
   input wire logic feat_valid, // Feature frame offered
   output logic feat_ready, // Feature frame taken when valid
   input wire logic [11:0][15:0] feat_cep, // c1..c12, [0] is c1
   input wire logic [15:0] feat_c0, // Zeroth cepstral coefficient
   input wire logic [15:0] feat_loge, // Log energy
   input wire logic [1:0] feat_rate, // Sampling rate code
   input wire logic feat_fe, // Front-end type flag
   input wire logic feat_last, // Last frame of the stream
   input wire logic cb_we, // Codebook load strobe
   input wire logic [11:0] cb_addr, // Codebook {set, pair, index}
   input wire logic [31:0] cb_wdata, // {element 2, element 1}
   input wire logic fill_en, // Send inverse sync while idle
   output logic tx_valid, // Serial bit offered
   input wire logic tx_ready, // Channel takes the bit
   output logic tx_bit // Serial data
);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [51:0] cost_f(input logic signed [15:0] a0,
      input logic signed [15:0] a1, input logic [31:0] q,
      input logic [15:0] w0, input logic [15:0] w1);
      logic signed [16:0] d0;
      logic signed [16:0] d1;
      logic [33:0] s0;
      logic [33:0] s1;
      d0 = 17'(a0) - 17'($signed(q[15:0]));
      d1 = 17'(a1) - 17'($signed(q[31:16]));
      s0 = $unsigned(34'(d0) * 34'(d0));
      s1 = $unsigned(34'(d1) * 34'(d1));
      return 52'(s0) * 52'(w0) + 52'(s1) * 52'(w1);
   endfunction : cost_f

   function automatic logic [43:0] set_field(input logic [43:0] w,
      input logic [2:0] p, input logic [7:0] idx);
      logic [43:0] r;
      r = w;
      if (p == fvq_pkg::ENERGY_PAIR) begin
         r[fvq_pkg::EN_IDX_POS +: fvq_pkg::EN_IDX_W] = idx;
      end else begin
         r[int'(p) * fvq_pkg::CEP_IDX_W +: fvq_pkg::CEP_IDX_W] = idx[5:0];
      end
      return r;
   endfunction : set_field

   function automatic logic [31:0] hdr_code(input logic [15:0] h);
      logic [14:0] r;
      logic fb;
      r = '0;
      for (int i = 15; i >= 0; i--) begin
         fb = h[i] ^ r[14];
         r = {r[13:0], 1'b0} ^ (fb ? fvq_pkg::HDR_POLY : 15'h0000);
      end
      return {^{h, r}, r, h};
   endfunction : hdr_code

   function automatic logic [3:0] crc_step(input logic [3:0] c,
      input logic b);
      logic fb;
      fb = b ^ c[3];
      return {c[2:0], 1'b0} ^ (fb ? fvq_pkg::CRC_POLY : 4'h0);
   endfunction : crc_step

   ////////////////////////////////////////////////////////////////////////
   // Quantizer
   fvq_pkg::fvq_q_e q_st_r, q_st_nxt;
   logic [13:0][15:0] vec_r;
   logic set_r, last_r, fe_r;
   logic [1:0] rate_r;
   logic [2:0] iss_p_r, cmp_p_r;
   logic [7:0] iss_j_r, cmp_j_r, bidx_r;
   logic cmp_v_r, cmp_end_r;
   logic [51:0] best_r;
   logic [43:0] fw_r;
   logic [31:0] cb_q;
   logic wbank_r;
   logic [4:0] wslot_r;
   logic [1:0] bank_full_r, bank_last_r, bank_fe_r;
   logic [1:0][4:0] bank_n_r;
   logic [1:0][1:0] bank_rate_r;

   wire feat_acc = feat_valid & feat_ready;
   wire [7:0] iss_last = (iss_p_r == fvq_pkg::ENERGY_PAIR) ?
      fvq_pkg::EN_LAST_IDX : fvq_pkg::CEP_LAST_IDX;
   wire iss_end = iss_j_r == iss_last;
   wire iss_on = q_st_r == fvq_pkg::Q_RUN;
   wire [11:0] cb_raddr = {set_r, iss_p_r, iss_j_r};
   wire is_en = cmp_p_r == fvq_pkg::ENERGY_PAIR;
   // Identity weight for the cepstral pairs
   wire [15:0] w0 = !is_en ? fvq_pkg::W_UNIT :
      (set_r ? fvq_pkg::W_HI_C0 : fvq_pkg::W_LO_C0);
   wire [15:0] w1 = !is_en ? fvq_pkg::W_UNIT :
      (set_r ? fvq_pkg::W_HI_EN : fvq_pkg::W_LO_EN);
   wire [51:0] cost = cost_f(vec_r[{cmp_p_r, 1'b0}],
      vec_r[{cmp_p_r, 1'b1}], cb_q, w0, w1);
   // Strict compare keeps the earlier index on a tie
   wire better = (cmp_j_r == 8'h00) | (cost < best_r);
   wire [7:0] win_idx = better ? cmp_j_r : bidx_r;
   wire commit = cmp_v_r & cmp_end_r & is_en;
   wire [43:0] fs_wdata = set_field(fw_r, fvq_pkg::ENERGY_PAIR, win_idx);
   wire bank_close = commit & (last_r | (wslot_r == fvq_pkg::SLOT_LAST));

   // A new frame waits while its bank still holds an unsent multiframe
   assign feat_ready = (q_st_r == fvq_pkg::Q_IDLE) & ~bank_full_r[wbank_r];

   fvq_mem #(.W(fvq_pkg::CB_W), .AW(fvq_pkg::CB_AW)) u_codebook (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(cb_we),
      .wr_addr(cb_addr),
      .wr_data(cb_wdata),
      .rd_en(iss_on),
      .rd_addr(cb_raddr),
      .rd_data(cb_q)
   );

   always_comb begin
      q_st_nxt = q_st_r;
      case (q_st_r)
         fvq_pkg::Q_IDLE: if (feat_acc) q_st_nxt = fvq_pkg::Q_RUN;
         fvq_pkg::Q_RUN: begin
            if (iss_end && iss_p_r == fvq_pkg::ENERGY_PAIR) begin
               q_st_nxt = fvq_pkg::Q_DRAIN;
            end
         end
         fvq_pkg::Q_DRAIN: if (commit) q_st_nxt = fvq_pkg::Q_IDLE;
         default: q_st_nxt = fvq_pkg::Q_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_st_r <= fvq_pkg::Q_IDLE;
         vec_r <= '0;
         {set_r, last_r, fe_r, rate_r} <= '0;
         {iss_p_r, iss_j_r, cmp_p_r, cmp_j_r, cmp_v_r, cmp_end_r} <= '0;
      end else begin
         q_st_r <= q_st_nxt;
         if (feat_acc) begin
            vec_r <= {feat_loge, feat_c0, feat_cep};
            set_r <= feat_rate == fvq_pkg::RATE_16K;
            {last_r, fe_r, rate_r} <= {feat_last, feat_fe, feat_rate};
            {iss_p_r, iss_j_r} <= '0;
         end else if (iss_on) begin
            iss_j_r <= iss_end ? 8'h00 : iss_j_r + 8'h01;
            iss_p_r <= iss_end ? iss_p_r + 3'h1 : iss_p_r;
         end
         cmp_v_r <= iss_on;
         {cmp_p_r, cmp_j_r, cmp_end_r} <= {iss_p_r, iss_j_r, iss_end};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {best_r, bidx_r, fw_r} <= '0;
      end else if (cmp_v_r) begin
         if (better) begin
            best_r <= cost;
            bidx_r <= cmp_j_r;
         end
         if (cmp_end_r) fw_r <= set_field(fw_r, cmp_p_r, win_idx);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmitter
   fvq_pkg::fvq_tx_e tx_st_r, tx_st_nxt;
   logic [47:0] sr_r;
   logic [43:0] frame_sr_r, hold_r, fs_q;
   logic [6:0] bcnt_r;
   logic [4:0] slot_r, rd_slot_r;
   logic [3:0] crc_r, mf_cnt_r;
   logic rbank_r, rd_pend_r;

   wire tx_acc = tx_valid & tx_ready;
   wire in_shdr = tx_st_r == fvq_pkg::TX_SHDR;
   wire in_frame = tx_st_r == fvq_pkg::TX_FRAME;
   wire in_crc = tx_st_r == fvq_pkg::TX_CRC;
   wire in_fill = tx_st_r == fvq_pkg::TX_FILL;
   wire in_idle = tx_st_r == fvq_pkg::TX_IDLE;
   wire start_mf = in_idle & bank_full_r[rbank_r];
   wire start_fill = in_idle & ~bank_full_r[rbank_r] & fill_en;
   wire fill_end = in_fill & tx_acc & (bcnt_r == fvq_pkg::WORD_LAST);
   wire shdr_end = in_shdr & tx_acc & (bcnt_r == fvq_pkg::SHDR_LAST);
   wire frame_end = in_frame & tx_acc & (bcnt_r == fvq_pkg::FRAME_LAST);
   wire crc_end = in_crc & tx_acc & (bcnt_r == fvq_pkg::CRC_LAST);
   wire mf_end = crc_end & (slot_r == fvq_pkg::SLOT_LAST);
   wire load_frame = shdr_end | (frame_end & ~slot_r[0]) |
      (crc_end & ~mf_end);
   wire [4:0] next_slot = shdr_end ? 5'h00 : slot_r + 5'h01;
   wire fs_re = start_mf | load_frame;
   wire [4:0] fs_rslot = start_mf ? 5'h00 : next_slot + 5'h01;
   wire [15:0] hdr_data = {fvq_pkg::HDR_EXP, mf_cnt_r, bank_fe_r[rbank_r],
      bank_rate_r[rbank_r]};

   assign tx_valid = ~in_idle;
   // Sync, header and frame fields leave their register from bit 0 upward; the CRC leaves from bit 3 down
   assign tx_bit = in_frame ? frame_sr_r[0] : (in_crc ? crc_r[3] : sr_r[0]);

   fvq_mem #(.W(fvq_pkg::FRAME_BITS), .AW(fvq_pkg::FS_AW)) u_frame_store (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(commit),
      .wr_addr({wbank_r, wslot_r}),
      .wr_data(fs_wdata),
      .rd_en(fs_re),
      .rd_addr({rbank_r, fs_rslot}),
      .rd_data(fs_q)
   );

   always_comb begin
      tx_st_nxt = tx_st_r;
      case (tx_st_r)
         fvq_pkg::TX_IDLE: begin
            if (start_mf) tx_st_nxt = fvq_pkg::TX_SHDR;
            else if (start_fill) tx_st_nxt = fvq_pkg::TX_FILL;
         end
         fvq_pkg::TX_FILL: if (fill_end) tx_st_nxt = fvq_pkg::TX_IDLE;
         fvq_pkg::TX_SHDR: if (shdr_end) tx_st_nxt = fvq_pkg::TX_FRAME;
         fvq_pkg::TX_FRAME: begin
            if (frame_end && slot_r[0]) tx_st_nxt = fvq_pkg::TX_CRC;
         end
         fvq_pkg::TX_CRC: begin
            if (mf_end) tx_st_nxt = fvq_pkg::TX_IDLE;
            else if (crc_end) tx_st_nxt = fvq_pkg::TX_FRAME;
         end
         default: tx_st_nxt = fvq_pkg::TX_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_st_r <= fvq_pkg::TX_IDLE;
         {sr_r, bcnt_r, slot_r} <= '0;
      end else begin
         tx_st_r <= tx_st_nxt;
         if (start_mf) begin
            sr_r <= {hdr_code(hdr_data), fvq_pkg::SYNC_WORD};
         end else if (start_fill) begin
            sr_r <= {32'h0000_0000, fvq_pkg::INV_SYNC};
         end else if (tx_acc && (in_shdr || in_fill)) begin
            sr_r <= {1'b0, sr_r[47:1]};
         end
         if (in_idle || fill_end || shdr_end || frame_end || crc_end) begin
            bcnt_r <= 7'h00;
         end else if (tx_acc) begin
            bcnt_r <= bcnt_r + 7'h01;
         end
         if (load_frame) slot_r <= next_slot;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {frame_sr_r, hold_r, crc_r, rd_slot_r, rd_pend_r} <= '0;
      end else begin
         rd_pend_r <= fs_re;
         rd_slot_r <= fs_rslot;
         if (rd_pend_r) begin
            hold_r <= (rd_slot_r < bank_n_r[rbank_r]) ? fs_q : '0;
         end
         if (load_frame) begin
            frame_sr_r <= hold_r;
         end else if (in_frame && tx_acc) begin
            frame_sr_r <= {1'b0, frame_sr_r[43:1]};
         end
         // CRC covers both frames and leaves top term first
         if (shdr_end || crc_end) begin
            crc_r <= 4'h0;
         end else if (in_frame && tx_acc) begin
            crc_r <= crc_step(crc_r, frame_sr_r[0]);
         end else if (in_crc && tx_acc) begin
            crc_r <= {crc_r[2:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bank hand-off between quantizer and transmitter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {wbank_r, wslot_r, rbank_r, bank_full_r, bank_last_r} <= '0;
         {bank_n_r, bank_rate_r, bank_fe_r} <= '0;
         mf_cnt_r <= fvq_pkg::MF_CNT_RST;
      end else begin
         if (mf_end) begin
            bank_full_r[rbank_r] <= 1'b0;
            rbank_r <= ~rbank_r;
            // A new stream restarts the count
            mf_cnt_r <= bank_last_r[rbank_r] ? fvq_pkg::MF_CNT_RST :
               mf_cnt_r + 4'h1;
         end
         if (bank_close) begin
            bank_full_r[wbank_r] <= 1'b1;
            bank_n_r[wbank_r] <= wslot_r + 5'h01;
            bank_last_r[wbank_r] <= last_r;
            bank_rate_r[wbank_r] <= rate_r;
            bank_fe_r[wbank_r] <= fe_r;
            wbank_r <= ~wbank_r;
            wslot_r <= 5'h00;
         end else if (commit) begin
            wslot_r <= wslot_r + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic [10:0] mf_bits_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mf_bits_r <= '0;
      end else if (start_mf) begin
         mf_bits_r <= '0;
      end else if (tx_acc && !in_fill) begin
         mf_bits_r <= mf_bits_r + 11'h001;
      end
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);

   sync_order_a: assert property (
      (in_shdr && bcnt_r <= fvq_pkg::WORD_LAST) |->
         tx_bit == fvq_pkg::SYNC_WORD[bcnt_r[3:0]])
      else $error("sync word bit out of order");
   fill_word_a: assert property (
      in_fill |-> tx_bit == fvq_pkg::INV_SYNC[bcnt_r[3:0]])
      else $error("inverse sync bit wrong");
   mf_length_a: assert property (
      mf_end |-> mf_bits_r == fvq_pkg::MF_BITS - 11'h001)
      else $error("multiframe length not 144 octets");
   hdr_to_frame_a: assert property (
      shdr_end |=> in_frame && slot_r == 5'h00 && bcnt_r == 7'h00)
      else $error("payload does not follow header");
   crc_after_pair_a: assert property (
      (frame_end && slot_r[0]) |=> in_crc && bcnt_r == 7'h00)
      else $error("crc does not follow frame pair");
   pad_zero_a: assert property (
      (in_frame && slot_r >= bank_n_r[rbank_r]) |-> !tx_bit)
      else $error("padding slot not zero");
   cnt_step_a: assert property (
      (mf_end && !bank_last_r[rbank_r]) |=>
         mf_cnt_r == 4'($past(mf_cnt_r) + 4'h1))
      else $error("multiframe counter did not advance");
   low_index_a: assert property (
      (cmp_v_r && cmp_j_r != 8'h00 && cost == best_r) |=>
         bidx_r == $past(bidx_r))
      else $error("tie did not keep lower index");
   search_time_a: assert property (
      feat_acc |-> ##[600:700] commit)
      else $error("frame search did not finish in time");

   mf_sent_c: cover property (mf_end);
   fill_sent_c: cover property (fill_end);
   last_mf_c: cover property (mf_end && bank_n_r[rbank_r] < 5'h18);
   wide_set_c: cover property (commit && set_r);

endmodule : fvq_framer

// File: hw/fvq_mem.sv
// Simple dual-port memory with registered read data
`timescale 1ns/1ps
module fvq_mem #(
   parameter int W = 32,
   parameter int AW = 12
) (
   input wire logic clk, // Clock
   input wire logic rst_n, // Async reset, active low
   input wire logic wr_en, // Write strobe
   input wire logic [AW-1:0] wr_addr, // Write address
   input wire logic [W-1:0] wr_data, // Write data
   input wire logic rd_en, // Read strobe
   input wire logic [AW-1:0] rd_addr, // Read address
   output logic [W-1:0] rd_data // Read data, one cycle after rd_en
);

   logic [W-1:0] mem_r [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
   end

   // A read in the same cycle as a write to that word returns the old word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem_r[rd_addr];
      end
   end

endmodule : fvq_mem

// File: hw/fvq_pkg.sv
// Constants and state types shared by the feature quantizer and framer
package fvq_pkg;

   // Feature vector layout
   localparam int FEAT_W = 16;
   localparam int NUM_CEP = 12;
   localparam int NUM_ELEM = 14;
   localparam logic [2:0] ENERGY_PAIR = 3'h6;

   // Codebook sizes, written as the last index of each search
   localparam logic [7:0] CEP_LAST_IDX = 8'h3f;
   localparam logic [7:0] EN_LAST_IDX = 8'hff;
   localparam int CEP_IDX_W = 6;
   localparam int EN_IDX_W = 8;
   localparam int EN_IDX_POS = 36;
   localparam int FRAME_BITS = 44;

   // Memory shapes: codebook {set, pair, index}, frame store {bank, slot}
   localparam int CB_W = 32;
   localparam int CB_AW = 12;
   localparam int FS_AW = 6;
   localparam int COST_W = 52;

   // Energy-pair weights scaled by ten to keep the first decimal
   localparam logic [15:0] W_UNIT = 16'h0001;
   localparam logic [15:0] W_LO_C0 = 16'h387c;
   localparam logic [15:0] W_LO_EN = 16'h0093;
   localparam logic [15:0] W_HI_C0 = 16'h30c9;
   localparam logic [15:0] W_HI_EN = 16'h0078;
   localparam logic [1:0] RATE_16K = 2'h3;

   // Multiframe framing
   localparam logic [15:0] SYNC_WORD = 16'h87b2;
   localparam logic [15:0] INV_SYNC = 16'h784d;
   localparam logic [6:0] WORD_LAST = 7'h0f;
   localparam logic [6:0] SHDR_LAST = 7'h2f;
   localparam logic [6:0] FRAME_LAST = 7'h2b;
   localparam logic [6:0] CRC_LAST = 7'h03;
   localparam logic [4:0] SLOT_LAST = 5'h17;
   localparam logic [10:0] MF_BITS = 11'h480;
   localparam logic [14:0] HDR_POLY = 15'h5101;
   localparam logic [3:0] CRC_POLY = 4'h3;
   localparam logic [3:0] MF_CNT_RST = 4'h1;
   localparam logic [8:0] HDR_EXP = 9'h000;

   typedef enum logic [4:0] {
      TX_IDLE = 5'h01,
      TX_FILL = 5'h02,
      TX_SHDR = 5'h04,
      TX_FRAME = 5'h08,
      TX_CRC = 5'h10
   } fvq_tx_e;

   typedef enum logic [2:0] {
      Q_IDLE = 3'h1,
      Q_RUN = 3'h2,
      Q_DRAIN = 3'h4
   } fvq_q_e;

endpackage : fvq_pkg

// File: verification/fvq_chan_model.sv
// Channel sink model: takes serial bits, optionally stalling
`timescale 1ns/1ps
module fvq_chan_model (
   input wire logic clk, // Clock
   input wire logic rst_n, // Async reset, active low
   input wire logic tx_valid, // Bit offered
   input wire logic tx_bit, // Serial data
   input wire logic stall_en, // Drop ready one cycle in three
   output logic tx_ready // Bit taken when high
);
   logic rx_q[$];
   logic [1:0] ph_r;
   // Ready changes only after an edge, so an offered bit is never torn
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_r <= 2'h0;
         tx_ready <= 1'b0;
      end else begin
         ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
         tx_ready <= !(stall_en && ph_r == 2'h2);
         if (tx_valid && tx_ready) rx_q.push_back(tx_bit);
      end
   end
endmodule : fvq_chan_model

// File: verification/tb.sv
// Testbench: codebook load, multiframes, fill words
`timescale 1ns/1ps
module tb;
   logic clk, rst_n, feat_valid, feat_ready, feat_fe, feat_last, cb_we;
   logic fill_en, tx_valid, tx_ready, tx_bit, stall_en;
   logic [11:0][15:0] feat_cep;
   logic [15:0] feat_c0, feat_loge;
   logic [1:0] feat_rate;
   logic [11:0] cb_addr;
   logic [31:0] cb_wdata;
   logic rx_q[$];
   logic exp_q[$];
   int n_mismatch = 0;
   int checks = 0;
   ////////////////////////////////////////////////////////////////////////
   fvq_framer dut_u (.clk(clk), .rst_n(rst_n), .feat_valid(feat_valid),
      .feat_ready(feat_ready), .feat_cep(feat_cep), .feat_c0(feat_c0),
      .feat_loge(feat_loge), .feat_rate(feat_rate), .feat_fe(feat_fe),
      .feat_last(feat_last), .cb_we(cb_we), .cb_addr(cb_addr),
      .cb_wdata(cb_wdata), .fill_en(fill_en), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_bit(tx_bit));
   fvq_chan_model chan_u (.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid),
      .tx_bit(tx_bit), .stall_en(stall_en), .tx_ready(tx_ready));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   task automatic check(string nm, logic [87:0] seen, logic [87:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // Codevector element: set 1 runs the indices backwards
   function automatic int cbe(int s, int p, int j, int k);
      int n;
      int v;
      n = (p == 6) ? 255 : 63;
      v = s ? n - j : j;
      return 16 * (k ? ((v * 3) & n) : v);
   endfunction : cbe
   // Odd frames put each cepstral pair not at its last codevector midway between two codevectors to force ties
   function automatic int feat(int s, int f, int e);
      int p;
      int n;
      int t;
      int t2;
      p = e / 2;
      n = (p == 6) ? 255 : 63;
      t = (f * 7 + p * 9) & n;
      if (p == 6 && e % 2 == 1) t = (t + 100) & n;
      t2 = (f % 2 == 1 && t < n) ? t + 1 : t;
      return (cbe(s, p, t, e % 2) + cbe(s, p, t2, e % 2)) / 2;
   endfunction : feat
   function automatic logic [7:0] best(int s, int p, int x0, int x1);
      longint c;
      longint bc;
      int d0;
      int d1;
      int w0;
      int w1;
      int bj;
      w0 = (p < 6) ? 1 : (s ? 12489 : 14460);
      w1 = (p < 6) ? 1 : (s ? 120 : 147);
      bc = -1;
      bj = 0;
      for (int j = 0; j <= ((p == 6) ? 255 : 63); j++) begin
         d0 = x0 - cbe(s, p, j, 0);
         d1 = x1 - cbe(s, p, j, 1);
         c = longint'(w0) * d0 * d0 + longint'(w1) * d1 * d1;
         if (bc < 0 || c < bc) begin
            bc = c;
            bj = j;
         end
      end
      return 8'(bj);
   endfunction : best
   function automatic logic [43:0] fidx(int s, int f);
      logic [43:0] w;
      logic [7:0] ix;
      w = '0;
      for (int p = 0; p < 7; p++) begin
         ix = best(s, p, feat(s, f, 2 * p), feat(s, f, 2 * p + 1));
         if (p < 6) w[6 * p +: 6] = ix[5:0];
         else w[36 +: 8] = ix;
      end
      return w;
   endfunction : fidx
   // Header word plus systematic parity, then overall even parity
   function automatic logic [31:0] hdr(logic [15:0] h);
      logic [14:0] r;
      logic fb;
      r = '0;
      for (int i = 15; i >= 0; i--) begin
         fb = h[i] ^ r[14];
         r = {r[13:0], 1'b0} ^ (fb ? 15'h5101 : 15'h0000);
      end
      return {^{h, r}, r, h};
   endfunction : hdr
   function automatic logic [87:0] take(bit src, int off, int n);
      logic [87:0] v;
      v = '0;
      for (int i = 0; i < n; i++) v[i] = src ? rx_q[off + i] : exp_q[off + i];
      return v;
   endfunction : take
   ////////////////////////////////////////////////////////////////////////
   task automatic load_cb();
      for (int s = 0; s < 2; s++) begin
         for (int p = 0; p < 7; p++) begin
            for (int j = 0; j <= ((p == 6) ? 255 : 63); j++) begin
               @(posedge clk);
               cb_we <= 1'b1;
               cb_addr <= {s[0], p[2:0], j[7:0]};
               cb_wdata <= {16'(cbe(s, p, j, 1)), 16'(cbe(s, p, j, 0))};
            end
         end
      end
      @(posedge clk);
      cb_we <= 1'b0;
   endtask : load_cb
   task automatic send_frame(int f, logic [1:0] rate, logic fe, logic last);
      int i;
      int s;
      logic [11:0][15:0] cep;
      s = (rate == 2'h3);
      for (i = 0; i < 12; i++) cep[i] = 16'(feat(s, f, i));
      @(posedge clk);
      feat_valid <= 1'b1;
      feat_cep <= cep;
      feat_c0 <= 16'(feat(s, f, 12));
      feat_loge <= 16'(feat(s, f, 13));
      feat_rate <= rate;
      feat_fe <= fe;
      feat_last <= last;
      i = 0;
      @(negedge clk);
      while (feat_ready !== 1'b1 && i < 5000) begin
         @(negedge clk);
         i++;
      end
      @(posedge clk);
      feat_valid <= 1'b0;
      @(negedge clk);
      check("busy", 88'(feat_ready), 88'h0);
   endtask : send_frame
   task automatic build_mf(int f0, int nf, logic [1:0] rate, logic fe,
         logic [3:0] cnt);
      logic [31:0] hw;
      logic [43:0] fw;
      logic [15:0] sw;
      logic [3:0] c;
      logic fb;
      exp_q.delete();
      sw = 16'h87b2;
      hw = hdr({9'h000, cnt, fe, rate});
      for (int i = 0; i < 16; i++) exp_q.push_back(sw[i]);
      for (int i = 0; i < 32; i++) exp_q.push_back(hw[i]);
      c = 4'h0;
      for (int k = 0; k < 24; k++) begin
         fw = (k < nf) ? fidx(rate == 2'h3, f0 + k) : 44'h0;
         for (int i = 0; i < 44; i++) begin
            exp_q.push_back(fw[i]);
            fb = fw[i] ^ c[3];
            c = {c[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
         end
         if (k % 2 == 1) begin
            for (int i = 3; i >= 0; i--) exp_q.push_back(c[i]);
            c = 4'h0;
         end
      end
   endtask : build_mf
   // Run frames through and compare the whole multiframe field by field
   task automatic run_mf(int f0, int nf, logic [1:0] rate, logic fe,
         logic last, logic [3:0] cnt);
      int b;
      chan_u.rx_q.delete();
      for (int f = 0; f < nf; f++)
         send_frame(f0 + f, rate, fe, last && f == nf - 1);
      build_mf(f0, nf, rate, fe, cnt);
      for (int i = 0; i < 6000 && chan_u.rx_q.size() < 1152; i++)
         @(posedge clk);
      repeat (40) @(posedge clk);
      rx_q = chan_u.rx_q;
      check("idle", 88'(tx_valid), 88'h0);
      check("len", 88'(rx_q.size()), 88'd1152);
      check("sync", take(1, 0, 16), take(0, 0, 16));
      check("hdr", take(1, 16, 32), take(0, 16, 32));
      for (int k = 0; k < 12; k++) begin
         b = 48 + 92 * k;
         check("frm0", take(1, b, 44), take(0, b, 44));
         check("frm1", take(1, b + 44, 44), take(0, b + 44, 44));
         check("crc", take(1, b + 88, 4), take(0, b + 88, 4));
      end
   endtask : run_mf
   ////////////////////////////////////////////////////////////////////////
   task automatic sc_full_16k();
      stall_en <= 1'b1;
      run_mf(0, 24, 2'h3, 1'b1, 1'b0, 4'h1);
   endtask : sc_full_16k
   task automatic sc_last_11k();
      stall_en <= 1'b0;
      run_mf(30, 2, 2'h1, 1'b0, 1'b1, 4'h2);
   endtask : sc_last_11k
   task automatic sc_restart_8k();
      stall_en <= 1'b1;
      run_mf(41, 2, 2'h0, 1'b1, 1'b1, 4'h1);
   endtask : sc_restart_8k
   task automatic sc_fill();
      chan_u.rx_q.delete();
      fill_en <= 1'b1;
      repeat (60) @(posedge clk);
      fill_en <= 1'b0;
      repeat (60) @(posedge clk);
      rx_q = chan_u.rx_q;
      check("fill_len", 88'(rx_q.size() % 16), 88'h0);
      check("fill_word", take(1, 0, 16), 88'h784d);
   endtask : sc_fill
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      {feat_valid, feat_fe, feat_last, cb_we, fill_en, stall_en} = '0;
      feat_cep = '0;
      feat_c0 = '0;
      feat_loge = '0;
      feat_rate = '0;
      cb_addr = '0;
      cb_wdata = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      load_cb();
      sc_full_16k();
      sc_last_11k();
      sc_restart_8k();
      sc_fill();
      end_sim();
   end
   // About 24k cycles are expected; 60k cycles means a hang
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      end_sim();
   end
endmodule : tb
